/* core/report_fifo.sv */
// width and depth parameterised fifo, one clock
`timescale 1ns/1ps
`default_nettype none
module report_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
   logic do_wr, do_rd;
   always_comb begin
      in_ready = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
      out_valid = wr_ff != rd_ff;
      do_wr = in_valid && in_ready;
      do_rd = out_valid && out_ready;
      nxt_wr = wr_ff + (AW+1)'(do_wr);
      nxt_rd = rd_ff + (AW+1)'(do_rd);
      out_data = mem[rd_ff[AW-1:0]];
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
      end
      if (do_wr) begin
         mem[wr_ff[AW-1:0]] <= in_data;
      end
   end
endmodule // report_fifo
`default_nettype wire

/* core/touch_report_framer.sv */
// touch input report framer with max-touches report, attention line and power state
// Notes on behaviour
// - status byte bit0 is touch flag
// - byte 2 carries touch index from zero
// - positions limited to twelve bits
// - x in bytes 3-4, y in 7-8
// - geometry off leaves bytes 5,6,9,10 zero
// - byte 11 width only with geometry on
// - byte 13 height only with geometry on
// - bytes 15-16 timestamp at 10 kHz
// - byte 17 count passed through from touch input in every touch report
// - host reads and writes max touches
// - max touches report 18 bytes, one value
// - max touches clamped to configured limit
// - open-drain active-low attention output
// - attention low while reports remain unread
// - set power sleep enters low power, set power on leaves it
// - touch report 18 bytes, one touch
// - geometry on gives centre x/y fields
`timescale 1ns/1ps
`default_nettype none
module touch_report_framer #(
   parameter int FIFO_DEPTH = 8,
   parameter logic [7:0] TOUCH_REPORT_ID = 8'h01,
   parameter logic [7:0] MAXT_REPORT_ID = 8'h02
) (
   input wire logic CORE_CLK,
   input wire logic SRST,
   input wire logic LINK_CLK,
   input wire logic LINK_SRST,
   input wire logic GEOMETRY_REPORT_ENABLE,
   input wire logic [7:0] CONFIG_MAX_TOUCHES,
   input wire logic TOUCH_VALID,
   output logic TOUCH_READY,
   input wire touch_report_pkg::touch_s TOUCH_IN,
   input wire logic MAXT_WRITE,
   input wire logic [7:0] MAXT_WRITE_VALUE,
   output logic [7:0] MAX_TOUCHES,
   input wire logic SET_POWER_SLEEP,
   input wire logic SET_POWER_ON,
   output logic LOW_POWER,
   input wire logic MAXT_READ_REQ,
   input wire logic LINK_READ,
   output logic [7:0] LINK_DATA,
   output logic LINK_LAST,
   output logic LINK_VALID,
   input wire logic HOST_ATTENTION_LINE_IN,
   output logic HOST_ATTENTION_LINE_OUT,
   output logic HOST_ATTENTION_LINE_OE
);
   import touch_report_pkg::*;

   typedef enum {IDLE, SEND_TOUCH, SEND_MAXT} frame_e;

   frame_e state_ff, nxt_state;
   logic [4:0] pos_ff, nxt_pos;
   touch_s cur_ff, nxt_cur;
   logic geom_ff, nxt_geom;
   logic [7:0] maxt_ff, nxt_maxt;
   logic low_ff, nxt_low;
   logic [12:0] div_ff, nxt_div;
   logic [15:0] stamp_ff, nxt_stamp;
   logic [15:0] rstamp_ff, nxt_rstamp;
   logic maxt_pend_ff, nxt_maxt_pend;
   logic [7:0] byte_val;
   logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
   report_byte_s f_in, f_out;
   logic unused_att;

   assign unused_att = HOST_ATTENTION_LINE_IN;

   // timestamp and control state
   always_comb begin
      nxt_div = div_ff;
      nxt_stamp = stamp_ff;
      if (div_ff == STAMP_DIV_LAST) begin
         nxt_div = '0;
         nxt_stamp = stamp_ff + 16'h0001;
      end else begin
         nxt_div = div_ff + 13'h0001;
      end
      nxt_maxt = maxt_ff;
      if (MAXT_WRITE) begin
         nxt_maxt = (MAXT_WRITE_VALUE > CONFIG_MAX_TOUCHES) ? CONFIG_MAX_TOUCHES : MAXT_WRITE_VALUE;
      end else if (maxt_ff > CONFIG_MAX_TOUCHES) begin
         nxt_maxt = CONFIG_MAX_TOUCHES;
      end
      nxt_low = low_ff;
      if (SET_POWER_SLEEP) begin
         nxt_low = 1'b1;
      end else if (SET_POWER_ON) begin
         nxt_low = 1'b0;
      end
      // held until the idle framer takes it; a new request in that cycle wins
      nxt_maxt_pend = (maxt_pend_ff && (state_ff != IDLE)) || MAXT_READ_REQ;
   end

   // byte selection for the report being framed
   always_comb begin
      byte_val = 8'h00;
      if (state_ff == SEND_MAXT) begin
         if (pos_ff == 5'h00) begin
            byte_val = MAXT_REPORT_ID;
         end else if (pos_ff == 5'h01) begin
            byte_val = maxt_ff;
         end
      end else begin
         case (pos_ff)
            5'h00: byte_val = TOUCH_REPORT_ID;
            BYTE_STATUS: byte_val = {7'h00, cur_ff.touched};
            BYTE_INDEX: byte_val = cur_ff.index;
            BYTE_X_LO: byte_val = cur_ff.x[7:0];
            BYTE_X_HI: byte_val = {4'h0, cur_ff.x[11:8]};
            BYTE_CX_LO: byte_val = geom_ff ? cur_ff.cx[7:0] : 8'h00;
            BYTE_CX_HI: byte_val = geom_ff ? {4'h0, cur_ff.cx[11:8]} : 8'h00;
            BYTE_Y_LO: byte_val = cur_ff.y[7:0];
            BYTE_Y_HI: byte_val = {4'h0, cur_ff.y[11:8]};
            BYTE_CY_LO: byte_val = geom_ff ? cur_ff.cy[7:0] : 8'h00;
            BYTE_CY_HI: byte_val = geom_ff ? {4'h0, cur_ff.cy[11:8]} : 8'h00;
            BYTE_WIDTH: byte_val = geom_ff ? cur_ff.width : 8'h00;
            BYTE_HEIGHT: byte_val = geom_ff ? cur_ff.height : 8'h00;
            BYTE_TIME_LO: byte_val = rstamp_ff[7:0];
            BYTE_TIME_HI: byte_val = rstamp_ff[15:8];
            BYTE_COUNT: byte_val = cur_ff.count;
            default: byte_val = 8'h00;
         endcase
      end
   end

   // framing state machine; fifo back-pressure stalls it
   always_comb begin
      nxt_state = state_ff;
      nxt_pos = pos_ff;
      nxt_cur = cur_ff;
      nxt_geom = geom_ff;
      nxt_rstamp = rstamp_ff;
      TOUCH_READY = 1'b0;
      f_in_valid = 1'b0;
      f_in.data = byte_val;
      f_in.last = pos_ff == LAST_BYTE;
      case (state_ff)
         IDLE: begin
            if (maxt_pend_ff) begin
               nxt_state = SEND_MAXT;
               nxt_pos = '0;
            end else if (!low_ff) begin
               // sleeping holds touches off so no touch report forms; max touches reports still do
               TOUCH_READY = 1'b1;
               if (TOUCH_VALID) begin
                  nxt_cur = TOUCH_IN;
                  nxt_geom = GEOMETRY_REPORT_ENABLE;
                  nxt_rstamp = stamp_ff;
                  nxt_pos = '0;
                  nxt_state = SEND_TOUCH;
               end
            end
         end
         SEND_TOUCH, SEND_MAXT: begin
            f_in_valid = 1'b1;
            if (f_in_ready) begin
               nxt_pos = pos_ff + 5'h01;
               if (pos_ff == LAST_BYTE) begin
                  nxt_state = IDLE;
               end
            end
         end
         default: nxt_state = IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         state_ff <= IDLE;
         pos_ff <= '0;
         cur_ff <= '0;
         geom_ff <= 1'b0;
         maxt_ff <= MAXT_RESET;
         low_ff <= 1'b0;
         div_ff <= '0;
         stamp_ff <= '0;
         rstamp_ff <= '0;
         maxt_pend_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         pos_ff <= nxt_pos;
         cur_ff <= nxt_cur;
         geom_ff <= nxt_geom;
         maxt_ff <= nxt_maxt;
         low_ff <= nxt_low;
         div_ff <= nxt_div;
         stamp_ff <= nxt_stamp;
         rstamp_ff <= nxt_rstamp;
         maxt_pend_ff <= nxt_maxt_pend;
      end
   end

   assign MAX_TOUCHES = maxt_ff;
   assign LOW_POWER = low_ff;

   report_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(CORE_CLK),
      .srst(SRST),
      .in_valid(f_in_valid),
      .in_ready(f_in_ready),
      .in_data(f_in),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready),
      .out_data(f_out)
   );

   // crossing: core offers one byte by toggle, link returns a toggle on read
   logic [8:0] hold_ff, nxt_hold;
   logic req_ff, nxt_req;
   logic ack_s1_ff, ack_s2_ff;
   logic ack_ff, nxt_ack;
   logic req_s1_ff, req_s2_ff;
   logic [8:0] ldata_ff, nxt_ldata;
   logic lvalid_ff, nxt_lvalid;
   logic busy;

   // one byte in flight; the handshake is slow but safe for any phase
   always_comb begin
      busy = req_ff != ack_s2_ff;
      f_out_ready = !busy;
      nxt_hold = hold_ff;
      nxt_req = req_ff;
      if (!busy && f_out_valid) begin
         nxt_hold = f_out;
         nxt_req = !req_ff;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         hold_ff <= '0;
         req_ff <= 1'b0;
         ack_s1_ff <= 1'b0;
         ack_s2_ff <= 1'b0;
      end else begin
         hold_ff <= nxt_hold;
         req_ff <= nxt_req;
         ack_s1_ff <= ack_ff;
         ack_s2_ff <= ack_s1_ff;
      end
   end

   // link side: byte valid when request toggle differs from ack
   always_comb begin
      nxt_ack = ack_ff;
      nxt_ldata = ldata_ff;
      nxt_lvalid = lvalid_ff;
      if (!lvalid_ff && (req_s2_ff != ack_ff)) begin
         nxt_ldata = hold_ff; // stable while toggles differ
         nxt_lvalid = 1'b1;
      end else if (lvalid_ff && LINK_READ) begin
         nxt_lvalid = 1'b0;
         nxt_ack = !ack_ff;
      end
   end

   always_ff @(posedge LINK_CLK) begin
      if (LINK_SRST) begin
         req_s1_ff <= 1'b0;
         req_s2_ff <= 1'b0;
         ack_ff <= 1'b0;
         ldata_ff <= '0;
         lvalid_ff <= 1'b0;
      end else begin
         req_s1_ff <= req_ff;
         req_s2_ff <= req_s1_ff;
         ack_ff <= nxt_ack;
         ldata_ff <= nxt_ldata;
         lvalid_ff <= nxt_lvalid;
      end
   end

   assign LINK_DATA = ldata_ff[8:1];
   assign LINK_LAST = ldata_ff[0];
   assign LINK_VALID = lvalid_ff;

   // attention: low while any byte sits unread anywhere in the path
   logic att_ff, nxt_att;
   always_comb begin
      nxt_att = f_out_valid || busy || maxt_pend_ff || (state_ff != IDLE);
   end
   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         att_ff <= 1'b0;
      end else begin
         att_ff <= nxt_att;
      end
   end

   // open drain: only ever drives low, level style for the host
   assign HOST_ATTENTION_LINE_OUT = 1'b0;
   assign HOST_ATTENTION_LINE_OE = att_ff;
endmodule // touch_report_framer
`default_nettype wire

/* core/touch_report_pkg.sv */
// shared constants and carriers for the touch report framer
package touch_report_pkg;
   localparam int REPORT_LEN = 18;
   localparam logic [4:0] BYTE_STATUS = 5'h01;
   localparam logic [4:0] BYTE_INDEX = 5'h02;
   localparam logic [4:0] BYTE_X_LO = 5'h03;
   localparam logic [4:0] BYTE_X_HI = 5'h04;
   localparam logic [4:0] BYTE_CX_LO = 5'h05;
   localparam logic [4:0] BYTE_CX_HI = 5'h06;
   localparam logic [4:0] BYTE_Y_LO = 5'h07;
   localparam logic [4:0] BYTE_Y_HI = 5'h08;
   localparam logic [4:0] BYTE_CY_LO = 5'h09;
   localparam logic [4:0] BYTE_CY_HI = 5'h0A;
   localparam logic [4:0] BYTE_WIDTH = 5'h0B;
   localparam logic [4:0] BYTE_HEIGHT = 5'h0D;
   localparam logic [4:0] BYTE_TIME_LO = 5'h0F;
   localparam logic [4:0] BYTE_TIME_HI = 5'h10;
   localparam logic [4:0] BYTE_COUNT = 5'h11;
   localparam logic [4:0] LAST_BYTE = 5'h11;
   localparam logic [7:0] MAXT_RESET = 8'h10;
   localparam int CORE_HZ = 50000000;
   localparam int STAMP_HZ = 10000;
   localparam int STAMP_DIV = CORE_HZ / STAMP_HZ;
   localparam logic [12:0] STAMP_DIV_LAST = 13'(STAMP_DIV - 1);

   typedef struct packed {
      logic touched;
      logic [7:0] index;
      logic [11:0] x;
      logic [11:0] y;
      logic [11:0] cx;
      logic [11:0] cy;
      logic [7:0] width;
      logic [7:0] height;
      logic [7:0] count;
   } touch_s;

   typedef struct packed {
      logic [7:0] data;
      logic last;
   } report_byte_s;
endpackage

/* sim/link_host_model.sv */
// host model draining report bytes on the link clock
`timescale 1ns/1ps
`default_nettype none
module link_host_model (
   input wire logic link_clk,
   input wire logic link_srst,
   input wire logic stall,
   input wire logic valid,
   input wire logic last,
   input wire logic [7:0] data,
   input wire logic att_n,
   output logic read
);
   logic [8:0] rx_q[$];
   // reads only while attention is low, never on an edge
   always @(posedge link_clk) begin
      read <= 1'b0;
      if (link_srst) begin
         rx_q.delete();
      end else if (valid && !read && !stall && !att_n) begin
         rx_q.push_back({last, data});
         read <= 1'b1;
      end
   end
endmodule // link_host_model
`default_nettype wire

/* sim/tb_top.sv */
// self-checking testbench for the touch report framer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import touch_report_pkg::*;
   logic core_clk = 0, link_clk = 0, srst = 1, geo = 0, tv = 0, mw = 0, sps = 0, spo = 0, mrr = 0, stall = 0;
   logic ready, low_pwr, l_rd, l_last, l_valid, att_out, att_oe;
   logic [7:0] cfg = 8'h0C, mwv = 8'h00, max_t, l_data;
   touch_s tin = '0;
   int miscompares = 0, n_tests = 0, cyc = 0, take_cyc = 0, rel_cyc = 0;
   wire logic att_n = att_oe ? att_out : 1'b1; // pull-up when released
   initial forever #10 core_clk = ~core_clk;
   initial begin
      #7;
      forever #15 link_clk = ~link_clk;
   end
   touch_report_framer touch_report_framer_i (.CORE_CLK(core_clk), .SRST(srst), .LINK_CLK(link_clk),
      .LINK_SRST(srst), .GEOMETRY_REPORT_ENABLE(geo), .CONFIG_MAX_TOUCHES(cfg), .TOUCH_VALID(tv),
      .TOUCH_READY(ready), .TOUCH_IN(tin), .MAXT_WRITE(mw), .MAXT_WRITE_VALUE(mwv), .MAX_TOUCHES(max_t),
      .SET_POWER_SLEEP(sps), .SET_POWER_ON(spo), .LOW_POWER(low_pwr), .MAXT_READ_REQ(mrr), .LINK_READ(l_rd),
      .LINK_DATA(l_data), .LINK_LAST(l_last), .LINK_VALID(l_valid), .HOST_ATTENTION_LINE_IN(att_n),
      .HOST_ATTENTION_LINE_OUT(att_out), .HOST_ATTENTION_LINE_OE(att_oe));
   link_host_model link_host_model_i (.link_clk(link_clk), .link_srst(srst), .stall(stall), .valid(l_valid),
      .last(l_last), .data(l_data), .att_n(att_n), .read(l_rd));
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 40000) begin
         miscompares++;
         final_report();
      end
   end
   function automatic logic [7:0] eb(input touch_s t, input logic g, input int i);
      case (i)
         0: return 8'h01;
         1: return {7'h00, t.touched};
         2: return t.index;
         3: return t.x[7:0];
         4: return {4'h0, t.x[11:8]};
         5: return g ? t.cx[7:0] : 8'h00;
         6: return g ? {4'h0, t.cx[11:8]} : 8'h00;
         7: return t.y[7:0];
         8: return {4'h0, t.y[11:8]};
         9: return g ? t.cy[7:0] : 8'h00;
         10: return g ? {4'h0, t.cy[11:8]} : 8'h00;
         11: return g ? t.width : 8'h00;
         13: return g ? t.height : 8'h00;
         17: return t.count;
         default: return 8'h00;
      endcase
   endfunction
   // bounded, a lost byte shows up as a miscompare
   task automatic wait_bytes(input int n);
      repeat (3000) if (link_host_model_i.rx_q.size() < n) @(negedge core_clk);
   endtask
   task automatic send(input touch_s t);
      tin = t;
      tv = 1;
      while (ready !== 1'b1) @(negedge core_clk);
      @(negedge core_clk);
      take_cyc = cyc;
      tv = 0;
   endtask
   // stamp expected from the edge that took the touch, ticks since reset release
   task automatic check_touch(input touch_s t, input logic g);
      logic [8:0] b;
      logic [15:0] st;
      geo = g;
      send(t);
      st = 16'((take_cyc - rel_cyc - 1) / STAMP_DIV);
      wait_bytes(18);
      for (int i = 0; i < 18; i++) begin
         b = link_host_model_i.rx_q.pop_front();
         chk(b, {i == 17, i == 15 ? st[7:0] : i == 16 ? st[15:8] : eb(t, g, i)});
      end
   endtask
   task automatic att_test;
      stall = 1;
      send('{1'b1, 8'h02, 12'h001, 12'h002, 12'h000, 12'h000, 8'h00, 8'h00, 8'h00});
      repeat (100) @(negedge core_clk);
      chk({8'h00, att_n}, 9'h000);
      stall = 0;
      wait_bytes(9);
      chk({8'h00, att_n}, 9'h000);
      wait_bytes(18);
      link_host_model_i.rx_q.delete();
      repeat (40) @(negedge core_clk);
      chk({8'h00, att_n}, 9'h001);
   endtask
   task automatic maxt(input logic [7:0] v, input logic [7:0] e);
      logic [8:0] b;
      mwv = v;
      mw = 1;
      @(negedge core_clk);
      mw = 0;
      chk({1'b0, max_t}, {1'b0, e});
      mrr = 1;
      @(negedge core_clk);
      mrr = 0;
      wait_bytes(18);
      for (int i = 0; i < 18; i++) begin
         b = link_host_model_i.rx_q.pop_front();
         chk(b, {i == 17, i == 0 ? 8'h02 : i == 1 ? e : 8'h00});
      end
   endtask
   // sleep and wake together: sleep must win
   task automatic power;
      sps = 1;
      spo = 1;
      @(negedge core_clk);
      sps = 0;
      spo = 0;
      @(negedge core_clk);
      chk({7'h00, low_pwr, ready}, 9'h002);
      maxt(8'h05, 8'h05);
      spo = 1;
      @(negedge core_clk);
      spo = 0;
      @(negedge core_clk);
      chk({7'h00, low_pwr, ready}, 9'h001);
   endtask
   initial begin
      repeat (5) @(negedge core_clk);
      srst = 0;
      rel_cyc = cyc;
      repeat (2) @(negedge core_clk);
      chk({1'b0, max_t}, 9'h00C);
      check_touch('{1'b1, 8'h00, 12'hFFF, 12'h123, 12'h456, 12'h789, 8'h21, 8'h32, 8'h03}, 1'b1);
      // let the stamp tick at least once so its bytes carry a nonzero value
      repeat (STAMP_DIV) @(negedge core_clk);
      check_touch('{1'b0, 8'h01, 12'hABC, 12'hF0F, 12'hFFF, 12'hFFF, 8'hFF, 8'hFF, 8'h00}, 1'b0);
      att_test();
      maxt(8'h20, 8'h0C);
      maxt(8'h03, 8'h03);
      power();
      cfg = 8'h02;
      repeat (2) @(negedge core_clk);
      chk({1'b0, max_t}, 9'h002);
      final_report();
   end
endmodule // tb_top
`default_nettype wire

/* sim/touch_report_framer_monitor.sv */
// port checker for the touch report framer
`timescale 1ns/1ps
`default_nettype none
module touch_report_framer_monitor (
   input wire logic CORE_CLK,
   input wire logic SRST,
   input wire logic LINK_CLK,
   input wire logic LINK_SRST,
   input wire logic [7:0] CONFIG_MAX_TOUCHES,
   input wire logic TOUCH_VALID,
   input wire logic TOUCH_READY,
   input wire logic MAXT_WRITE,
   input wire logic [7:0] MAXT_WRITE_VALUE,
   input wire logic [7:0] MAX_TOUCHES,
   input wire logic SET_POWER_SLEEP,
   input wire logic LOW_POWER,
   input wire logic LINK_READ,
   input wire logic [7:0] LINK_DATA,
   input wire logic LINK_VALID,
   input wire logic HOST_ATTENTION_LINE_OUT,
   input wire logic HOST_ATTENTION_LINE_OE
);
   logic [7:0] lim;
   assign lim = MAXT_WRITE_VALUE > CONFIG_MAX_TOUCHES ? CONFIG_MAX_TOUCHES : MAXT_WRITE_VALUE;
   property p_sleep;
      @(posedge CORE_CLK) disable iff (SRST) SET_POWER_SLEEP |=> LOW_POWER;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep request ignored");
   property p_refuse;
      @(posedge CORE_CLK) disable iff (SRST) LOW_POWER |-> !TOUCH_READY;
   endproperty
   a_refuse: assert property (p_refuse) else $error("touch taken while asleep");
   property p_clamp;
      @(posedge CORE_CLK) disable iff (SRST) MAXT_WRITE |=> MAX_TOUCHES == $past(lim);
   endproperty
   a_clamp: assert property (p_clamp) else $error("max touches not clamped");
   property p_od;
      @(posedge CORE_CLK) disable iff (SRST) HOST_ATTENTION_LINE_OE |-> !HOST_ATTENTION_LINE_OUT;
   endproperty
   a_od: assert property (p_od) else $error("attention driven high");
   property p_att_rise;
      @(posedge CORE_CLK) disable iff (SRST) TOUCH_VALID && TOUCH_READY |-> ##[1:3] HOST_ATTENTION_LINE_OE;
   endproperty
   a_att_rise: assert property (p_att_rise) else $error("attention late");
   property p_busy;
      @(posedge CORE_CLK) disable iff (SRST) TOUCH_VALID && TOUCH_READY |=> !TOUCH_READY [*8];
   endproperty
   a_busy: assert property (p_busy) else $error("touch taken mid report");
   property p_hold;
      @(posedge LINK_CLK) disable iff (LINK_SRST) LINK_VALID && !LINK_READ |=> LINK_VALID && $stable(LINK_DATA);
   endproperty
   a_hold: assert property (p_hold) else $error("link byte dropped before read");
   // valid is a registered link signal, so sampling it here cannot glitch
   property p_att_valid;
      @(posedge CORE_CLK) disable iff (SRST) LINK_VALID |-> HOST_ATTENTION_LINE_OE;
   endproperty
   a_att_valid: assert property (p_att_valid) else $error("attention released with byte unread");
endmodule // touch_report_framer_monitor
bind touch_report_framer touch_report_framer_monitor touch_report_framer_monitor_i (.CORE_CLK, .SRST, .LINK_CLK,
   .LINK_SRST, .CONFIG_MAX_TOUCHES, .TOUCH_VALID, .TOUCH_READY, .MAXT_WRITE, .MAXT_WRITE_VALUE, .MAX_TOUCHES,
   .SET_POWER_SLEEP, .LOW_POWER, .LINK_READ, .LINK_DATA, .LINK_VALID, .HOST_ATTENTION_LINE_OUT,
   .HOST_ATTENTION_LINE_OE);
`default_nettype wire
